// ### logic/aafr_cfg.svh
/*
 register offsets, reset values, field positions and limits of the
 access arbiter / factory restore block.
 assumes: included by bare name from design files only.
*/
`ifndef AAFR_CFG_SVH
`define AAFR_CFG_SVH

// parameter addresses as seen on the parameter port
`define AAFR_OFS_CHANNEL_LOCK  16'h011c
`define AAFR_OFS_RESTORE       16'h0404
`define AAFR_OFS_PANEL_LOCK    16'h3a02

// reset values
`define AAFR_RST_CHANNEL_LOCK  16'h0000
`define AAFR_RST_PANEL_LOCK    16'h0000

// bit 0 carries the lock and command values
`define AAFR_BIT_VALUE         0

// movement range in user position units, default scaling
`define AAFR_POS_MIN           (-32'sd268435456)
`define AAFR_POS_MAX           (32'sd268435455)

// cycles spent writing one parameter into storage
`define AAFR_SAVE_CYCLES       4

`endif

// ### logic/aafr_pkg.sv
/*
 types shared by the access arbiter / factory restore block.
 assumes: referenced by scope only, never imported.
*/
package aafr_pkg;

   // which channel holds exclusive access
   typedef enum logic [1:0] {
      AAFR_OWN_NONE  = 2'b00,
      AAFR_OWN_PANEL = 2'b01,
      AAFR_OWN_TOOL  = 2'b10
   } aafr_owner_t;

   // restore sequencer states
   typedef enum logic [1:0] {
      AAFR_RS_IDLE   = 2'b00,
      AAFR_RS_RELOAD = 2'b01,
      AAFR_RS_SAVE   = 2'b10
   } aafr_rstate_t;

endpackage

// ### logic/aafr_pos_clamp.sv
/*
 clamps the actual position to the movement range while jog runs.
 assumes: position comes from logic on clk_in; one cycle of latency.
*/
`timescale 1ns/10ps
`include "aafr_cfg.svh"

module aafr_pos_clamp #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rst_in,
   // position path
   input  wire logic                    jog_active_in,
   input  wire logic signed [WIDTH-1:0] pos_in,
   output logic signed [WIDTH-1:0]      pos_out
);

   if (WIDTH < 30) begin : g_width_chk
      $error("position width too small for range");
   end

   typedef struct packed {
      logic signed [WIDTH-1:0] pos;
   } aafr_clamp_st_t;

   aafr_clamp_st_t st_ff;
   aafr_clamp_st_t nxt_st;

   localparam logic signed [WIDTH-1:0] PMIN = WIDTH'(`AAFR_POS_MIN);
   localparam logic signed [WIDTH-1:0] PMAX = WIDTH'(`AAFR_POS_MAX);

   // limit only in jog
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.pos = pos_in;
      if (jog_active_in) begin
         if (pos_in < PMIN) nxt_st.pos = PMIN;
         else if (pos_in > PMAX) nxt_st.pos = PMAX;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   assign pos_out = st_ff.pos;

   jog_range_a: assert property (@(posedge clk_in) disable iff (rst_in)
      jog_active_in |=> (pos_out >= PMIN && pos_out <= PMAX))
      else $error("jog position outside movement range");

   free_pass_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !jog_active_in |=> pos_out == $past(pos_in))
      else $error("position altered outside jog");

endmodule

// ### logic/aafr_param_store.sv
/*
 default value table and non-volatile image of the parameter set.
 assumes: storage is flip-flops; load and save strobes from the
 restore sequencer on the same clock.
*/
`timescale 1ns/10ps
`include "aafr_cfg.svh"

module aafr_param_store #(
   parameter int          DEPTH = 4,
   parameter int          WIDTH = 16,
   parameter int          IDXW  = 2
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // sequencer side and power-on load
   input  wire logic             load_defaults_in,
   input  wire logic             save_in,
   input  wire logic [IDXW-1:0]  save_idx_in,
   input  wire logic             power_on_load_in,
   // parameter read
   input  wire logic [IDXW-1:0]  rd_idx_in,
   output logic [WIDTH-1:0]      active_out,
   output logic [WIDTH-1:0]      stored_out
);

   if (DEPTH > (1 << IDXW)) begin : g_depth_chk
      $error("index too narrow for depth");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] pend;   // defaults waiting for save
      logic [DEPTH-1:0][WIDTH-1:0] nvm;    // non-volatile image
      logic [DEPTH-1:0][WIDTH-1:0] act;    // active values
      logic [WIDTH-1:0]            rd_a;
      logic [WIDTH-1:0]            rd_s;
   } aafr_store_st_t;

   aafr_store_st_t st_ff;
   aafr_store_st_t nxt_st;
   logic [DEPTH-1:0][WIDTH-1:0] dflt;

   // default table: entry index as a plain default pattern
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_dflt
         assign dflt[g] = WIDTH'(g);
      end
   endgenerate

   // defaults go to pending, then word by word to storage
   always_comb begin
      nxt_st = st_ff;
      if (load_defaults_in) nxt_st.pend = dflt;
      if (save_in) nxt_st.nvm[save_idx_in] = st_ff.pend[save_idx_in];
      // active values change only at power-on load
      if (power_on_load_in) nxt_st.act = st_ff.nvm;
      nxt_st.rd_a = st_ff.act[rd_idx_in];
      nxt_st.rd_s = st_ff.nvm[rd_idx_in];
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   assign active_out = st_ff.rd_a;
   assign stored_out = st_ff.rd_s;

   act_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !power_on_load_in |=> st_ff.act == $past(st_ff.act))
      else $error("active values changed without power-on");

endmodule

// ### logic/aafr_top.sv
/*
 access arbiter, channel and panel locks, restore-to-defaults
 sequencer with completion readback, and jog range clamp.
 assumes: one clock, synchronous reset as power-on; pins pass a
 two-stage synchroniser here; parameter port from the same clock.
*/
`timescale 1ns/10ps
`include "aafr_cfg.svh"

module aafr_top #(
   parameter int NPARAM   = 4,
   parameter int PIDXW    = 2,
   parameter int POSW     = 32,
   parameter int REFW     = 16
) (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // parameter port
   input  wire logic                   par_wr_in,
   input  wire logic                   par_rd_in,
   input  wire logic [15:0]            par_addr_in,
   input  wire logic [15:0]            par_wdata_in,
   output logic [15:0]                 par_rdata_out,
   output logic                        par_ack_out,
   output logic                        par_err_out,
   // drive state
   input  wire logic                   power_stage_on_in,
   input  wire logic                   mode_active_in,
   input  wire logic                   jog_active_in,
   input  wire logic                   power_on_load_in,
   // panel and tool requests
   input  wire logic                   panel_jog_start_in,
   input  wire logic                   panel_tune_start_in,
   input  wire logic                   panel_par_change_in,
   input  wire logic                   panel_fault_reset_in,
   input  wire logic                   panel_restore_item_in,
   input  wire logic                   tool_excl_on_in,
   input  wire logic                   other_ctrl_req_in,
   // reference and switch pins
   input  wire logic [REFW-1:0]        analog_ref_in,
   input  wire logic [REFW-1:0]        pulse_train_input_in,
   input  wire logic [7:0]             safety_pins_in,
   // position
   input  wire logic signed [POSW-1:0] pos_in,
   // results
   output logic [1:0]                  owner_out,
   output logic [REFW-1:0]             analog_ref_out,
   output logic [REFW-1:0]             pulse_train_ref_out,
   output logic [7:0]                  safety_out,
   output logic                        panel_start_ok_out,
   output logic                        other_ctrl_ok_out,
   output logic [15:0]                 active_par_out,
   output logic [15:0]                 stored_par_out,
   output logic signed [POSW-1:0]      pos_out
);

   if (NPARAM < 1 || NPARAM > (1 << PIDXW)) begin : g_np_chk
      $error("parameter count does not fit the index");
   end
   if (REFW < 1) begin : g_refw_chk
      $error("reference width must be positive");
   end

   typedef struct packed {
      logic [REFW-1:0]           ana_s1;
      logic [REFW-1:0]           ana_s2;
      logic [REFW-1:0]           pti_s1;
      logic [REFW-1:0]           pti_s2;
      logic [7:0]                saf_s1;
      logic [7:0]                saf_s2;
      aafr_pkg::aafr_owner_t     owner;
      logic                      chan_lock;
      logic                      chan_lock_pend;
      logic                      panel_lock;
      aafr_pkg::aafr_rstate_t    rstate;
      logic [PIDXW-1:0]          save_idx;
      logic [2:0]                save_cnt;
      logic [15:0]               rdata;
      logic                      ack;
      logic                      err;
      logic [REFW-1:0]           ana_out;
      logic [REFW-1:0]           pti_out;
      logic [7:0]                saf_out;
   } aafr_top_st_t;

   aafr_top_st_t st_ff;
   aafr_top_st_t nxt_st;

   logic restore_req;
   logic load_defaults;
   logic save_strobe;
   logic panel_mode_start;

   localparam logic [2:0] SAVE_LAST = 3'(`AAFR_SAVE_CYCLES - 1);
   localparam logic [PIDXW-1:0] LAST_IDX = PIDXW'(NPARAM - 1);

   // panel starts a mode only when not locked
   assign panel_mode_start = (panel_jog_start_in | panel_tune_start_in)
                             & ~st_ff.panel_lock;
   // restore from the panel item or a parameter write with bit 0 set
   assign restore_req = ~power_stage_on_in
      & ((par_wr_in & par_addr_in == `AAFR_OFS_RESTORE
          & par_wdata_in[`AAFR_BIT_VALUE])
         | (panel_restore_item_in & ~st_ff.panel_lock))
      & st_ff.rstate == aafr_pkg::AAFR_RS_IDLE;
   assign load_defaults = st_ff.rstate == aafr_pkg::AAFR_RS_RELOAD;
   assign save_strobe = st_ff.rstate == aafr_pkg::AAFR_RS_SAVE
                        && st_ff.save_cnt == SAVE_LAST;

   // next state of the whole block
   always_comb begin
      nxt_st = st_ff;
      // pin synchronisers, second stage alone is read
      nxt_st.ana_s1 = analog_ref_in;
      nxt_st.ana_s2 = st_ff.ana_s1;
      nxt_st.pti_s1 = pulse_train_input_in;
      nxt_st.pti_s2 = st_ff.pti_s1;
      nxt_st.saf_s1 = safety_pins_in;
      nxt_st.saf_s2 = st_ff.saf_s1;

      // references pass only when nobody is exclusive
      if (st_ff.owner == aafr_pkg::AAFR_OWN_NONE) begin
         nxt_st.ana_out = st_ff.ana_s2;
         nxt_st.pti_out = st_ff.pti_s2;
      end else begin
         nxt_st.ana_out = '0;
         nxt_st.pti_out = '0;
      end
      nxt_st.saf_out = st_ff.saf_s2;

      // exclusive access: a single owner field, first come wins, panel wins a tie
      unique case (st_ff.owner)
         aafr_pkg::AAFR_OWN_NONE: begin
            if (panel_mode_start)
               nxt_st.owner = aafr_pkg::AAFR_OWN_PANEL;
            else if (tool_excl_on_in && !st_ff.chan_lock)
               nxt_st.owner = aafr_pkg::AAFR_OWN_TOOL;
         end
         aafr_pkg::AAFR_OWN_PANEL: begin
            if (!mode_active_in && !panel_mode_start)
               nxt_st.owner = aafr_pkg::AAFR_OWN_NONE;
         end
         aafr_pkg::AAFR_OWN_TOOL: begin
            if (!tool_excl_on_in)
               nxt_st.owner = aafr_pkg::AAFR_OWN_NONE;
         end
         default: nxt_st.owner = aafr_pkg::AAFR_OWN_NONE;
      endcase

      // parameter port: one-cycle answer
      nxt_st.ack   = par_wr_in | par_rd_in;
      nxt_st.err   = 1'b0;
      nxt_st.rdata = '0;
      if (par_wr_in) begin
         unique case (par_addr_in)
            `AAFR_OFS_CHANNEL_LOCK: begin
               if (!par_wdata_in[`AAFR_BIT_VALUE])
                  nxt_st.chan_lock = 1'b0;
               else if (mode_active_in)
                  nxt_st.chan_lock_pend = 1'b1;
               else
                  nxt_st.chan_lock = 1'b1;
               if (!par_wdata_in[`AAFR_BIT_VALUE])
                  nxt_st.chan_lock_pend = 1'b0;
            end
            `AAFR_OFS_RESTORE: begin
               nxt_st.err = power_stage_on_in;
            end
            `AAFR_OFS_PANEL_LOCK: begin
               nxt_st.panel_lock =
                  par_wdata_in[`AAFR_BIT_VALUE];
            end
            default: nxt_st.err = 1'b1;
         endcase
      end else if (par_rd_in) begin
         unique case (par_addr_in)
            `AAFR_OFS_CHANNEL_LOCK:
               nxt_st.rdata = {15'h0000, st_ff.chan_lock};
            `AAFR_OFS_RESTORE:
               nxt_st.rdata = {15'h0000,
                  st_ff.rstate != aafr_pkg::AAFR_RS_IDLE};
            `AAFR_OFS_PANEL_LOCK:
               nxt_st.rdata = {15'h0000, st_ff.panel_lock};
            default: nxt_st.err = 1'b1;
         endcase
      end
      // deferred lock lands once the mode has ended
      if (st_ff.chan_lock_pend && !mode_active_in) begin
         nxt_st.chan_lock      = 1'b1;
         nxt_st.chan_lock_pend = 1'b0;
      end

      // restore sequencer: reload, then save every entry
      unique case (st_ff.rstate)
         aafr_pkg::AAFR_RS_IDLE: begin
            if (restore_req)
               nxt_st.rstate = aafr_pkg::AAFR_RS_RELOAD;
         end
         aafr_pkg::AAFR_RS_RELOAD: begin
            nxt_st.rstate   = aafr_pkg::AAFR_RS_SAVE;
            nxt_st.save_idx = '0;
            nxt_st.save_cnt = '0;
         end
         aafr_pkg::AAFR_RS_SAVE: begin
            nxt_st.save_cnt = st_ff.save_cnt + 3'h1;
            if (save_strobe) begin
               nxt_st.save_cnt = '0;
               nxt_st.save_idx = st_ff.save_idx + PIDXW'(1);
               if (st_ff.save_idx == LAST_IDX)
                  nxt_st.rstate = aafr_pkg::AAFR_RS_IDLE;
            end
         end
         default: nxt_st.rstate = aafr_pkg::AAFR_RS_IDLE;
      endcase
   end

   // state register; reset is power-on with no owner
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_ff            <= '0;
         st_ff.chan_lock  <= 1'(`AAFR_RST_CHANNEL_LOCK);
         st_ff.panel_lock <= 1'(`AAFR_RST_PANEL_LOCK);
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign owner_out           = st_ff.owner;
   assign analog_ref_out      = st_ff.ana_out;
   assign pulse_train_ref_out = st_ff.pti_out;
   assign safety_out          = st_ff.saf_out;
   assign par_rdata_out       = st_ff.rdata;
   assign par_ack_out         = st_ff.ack;
   assign par_err_out         = st_ff.err;
   assign panel_start_ok_out  = ~st_ff.panel_lock;
   assign other_ctrl_ok_out   = ~st_ff.chan_lock
                                & other_ctrl_req_in;

   // parameter image and defaults
   aafr_param_store #(
      .DEPTH (NPARAM),
      .WIDTH (16),
      .IDXW  (PIDXW)
   ) u_store (
      .clk_in           (clk_in),
      .rst_in           (rst_in),
      .load_defaults_in (load_defaults),
      .save_in          (save_strobe),
      .save_idx_in      (st_ff.save_idx),
      .power_on_load_in (power_on_load_in),
      .rd_idx_in        (par_addr_in[PIDXW-1:0]),
      .active_out       (active_par_out),
      .stored_out       (stored_par_out)
   );

   // jog movement range
   aafr_pos_clamp #(
      .WIDTH (POSW)
   ) u_clamp (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .jog_active_in (jog_active_in),
      .pos_in        (pos_in),
      .pos_out       (pos_out)
   );

   sequence s_restore_go;
      st_ff.rstate == aafr_pkg::AAFR_RS_RELOAD;
   endsequence

   restore_busy_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_restore_go |=> st_ff.rstate == aafr_pkg::AAFR_RS_SAVE)
      else $error("restore did not enter save");
   busy_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (par_rd_in && par_addr_in == `AAFR_OFS_RESTORE
       && !par_wr_in && st_ff.rstate != aafr_pkg::AAFR_RS_IDLE)
      |=> par_rdata_out == 16'h0001)
      else $error("restore busy not reported");
   power_reject_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (power_stage_on_in && st_ff.rstate == aafr_pkg::AAFR_RS_IDLE)
      |=> st_ff.rstate == aafr_pkg::AAFR_RS_IDLE)
      else $error("restore started with power stage on");
   reject_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (par_wr_in && par_addr_in == `AAFR_OFS_RESTORE && power_stage_on_in)
      |=> par_err_out)
      else $error("rejected restore write not flagged");
   panel_grant_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_ff.owner == aafr_pkg::AAFR_OWN_NONE && panel_mode_start)
      |=> owner_out == 2'b01)
      else $error("panel not granted exclusive access");
   tool_grant_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_ff.owner == aafr_pkg::AAFR_OWN_NONE && tool_excl_on_in
       && !panel_mode_start && !st_ff.chan_lock)
      |=> owner_out == 2'b10)
      else $error("tool not granted exclusive access");
   owner_legal_a: assert property (@(posedge clk_in) disable iff (rst_in)
      owner_out != 2'b11)
      else $error("two channels exclusive");
   ref_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
      owner_out != 2'b00 |=> analog_ref_out == '0
                             && pulse_train_ref_out == '0)
      else $error("reference passed under exclusive access");
   lock_defer_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (par_wr_in && par_addr_in == `AAFR_OFS_CHANNEL_LOCK
       && par_wdata_in[0] && mode_active_in && !st_ff.chan_lock)
      |=> !st_ff.chan_lock)
      else $error("channel lock set during active mode");
   reset_owner_a: assert property (@(posedge clk_in)
      rst_in |=> owner_out == 2'b00)
      else $error("owner present after reset");

endmodule

// ### tb/aafr_par_master.sv
/*
 parameter port master standing in for the tool or the fieldbus.
 assumes: strobes change at the falling edge; answer within 4 cycles.
*/
`timescale 1ns/10ps

module aafr_par_master (
   // clock
   input  wire logic        clk_in,
   // parameter port
   output logic             par_wr_out,
   output logic             par_rd_out,
   output logic [15:0]      par_addr_out,
   output logic [15:0]      par_wdata_out,
   input  wire logic [15:0] par_rdata_in,
   input  wire logic        par_ack_in,
   input  wire logic        par_err_in
);
   // idle port at time zero
   initial begin
      par_wr_out = 1'b0;
      par_rd_out = 1'b0;
      par_addr_out = 16'hffff;
      par_wdata_out = 16'h0000;
   end

   // one strobe pulse, then take rdata and err with the ack
   task automatic xfer(input logic w, input logic [15:0] a, d,
                       output logic [15:0] q, output logic e);
      q = 16'hxxxx;
      e = 1'bx;
      @(negedge clk_in);
      par_wr_out = w;
      par_rd_out = !w;
      par_addr_out = a;
      par_wdata_out = d;
      @(negedge clk_in);
      par_wr_out = 1'b0;
      par_rd_out = 1'b0;
      par_addr_out = ~a;  // released address no longer shows the value
      par_wdata_out = ~d; // released data no longer shows the value
      for (int n = 0; n < 4; n++) begin
         if (par_ack_in === 1'b1) begin
            q = par_rdata_in;
            e = par_err_in;
            break;
         end
         @(negedge clk_in);
      end
   endtask

   // read the command until it shows zero, bounded
   task automatic poll(input logic [15:0] a, input int max,
                       output int cnt);
      logic [15:0] q;
      logic        e;
      for (cnt = 0; cnt < max; cnt++) begin
         xfer(1'b0, a, 16'h0000, q, e);
         if (q === 16'h0000) break;
      end
   endtask
endmodule

// ### tb/test_access_arbiter_factory_restore.sv
/*
 self-checking bench for the access arbiter / factory restore block.
 assumes: aafr_top with default parameters; partner drives the port.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
   n_errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end

module test_access_arbiter_factory_restore;
   logic               clk_in, rst_in, pwr, mode, jog, pol, pjog, pri;
   logic               ptune, tool, oreq, wr, rd, ack, err, e, pok, ook;
   logic [15:0]        aref, pulse_train_input, addr, wdata, rdata, q, aref_o, pti_o;
   logic [15:0]        actp, stp;
   logic [7:0]         spin, safe_o;
   logic [1:0]         owner;
   logic signed [31:0] pos, pos_o;
   logic [31:0]        seed;
   int                 n_errors, cmp_count, i, n;

   aafr_par_master m_u (.clk_in(clk_in), .par_wr_out(wr),
      .par_rd_out(rd), .par_addr_out(addr), .par_wdata_out(wdata),
      .par_rdata_in(rdata), .par_ack_in(ack), .par_err_in(err));

   aafr_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .par_wr_in(wr),
      .par_rd_in(rd), .par_addr_in(addr), .par_wdata_in(wdata),
      .par_rdata_out(rdata), .par_ack_out(ack), .par_err_out(err),
      .power_stage_on_in(pwr), .mode_active_in(mode),
      .jog_active_in(jog), .power_on_load_in(pol),
      .panel_jog_start_in(pjog), .panel_tune_start_in(ptune),
      .panel_par_change_in(1'b0), .panel_fault_reset_in(1'b0),
      .panel_restore_item_in(pri), .tool_excl_on_in(tool),
      .other_ctrl_req_in(oreq), .analog_ref_in(aref),
      .pulse_train_input_in(pulse_train_input), .safety_pins_in(spin), .pos_in(pos),
      .owner_out(owner), .analog_ref_out(aref_o),
      .pulse_train_ref_out(pti_o), .safety_out(safe_o),
      .panel_start_ok_out(pok), .other_ctrl_ok_out(ook),
      .active_par_out(actp), .stored_par_out(stp), .pos_out(pos_o));

   // clock, 4 ns period
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // expected position: range limit only in jog
   function automatic logic signed [31:0] clampf(
         input logic signed [31:0] p, input logic j);
      if (j && p < $signed(32'hf0000000)) return $signed(32'hf0000000);
      if (j && p > $signed(32'h0fffffff)) return $signed(32'h0fffffff);
      return p;
   endfunction

   task automatic tick(input int k);
      repeat (k) @(negedge clk_in);
   endtask

   task automatic acc(input logic w, input logic [15:0] a, d, eq,
                      input logic ee);
      m_u.xfer(w, a, d, q, e);
      `CHK("par err", ee, e)
      if (!w) `CHK("par rdata", eq, q)
   endtask

   task automatic wait_own(input logic [1:0] ex);
      for (int k = 0; k < 8 && owner !== ex; k++) tick(1);
      `CHK("owner", ex, owner)
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // watchdog, far beyond the expected run
   initial begin
      #40000;
      n_errors++;
      conclude;
   end

   // main sequence
   initial begin
      {pwr, mode, jog, pol, pjog, ptune, tool, oreq, pri} = 9'h000;
      {aref, pulse_train_input, spin, pos} = 72'h0;
      seed = 32'hecb55eb7;
      rst_in = 1'b1;
      tick(8);
      rst_in = 1'b0;
      `CHK("owner", 2'h0, owner)
      acc(1'b0, 16'h011c, 16'h0000, 16'h0000, 1'b0);
      acc(1'b0, 16'h3a02, 16'h0000, 16'h0000, 1'b0);
      acc(1'b0, 16'h0123, 16'h0000, 16'h0000, 1'b1);
      for (i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         {aref, pulse_train_input} = seed;
         tick(4);
         `CHK("aref", aref, aref_o)
         `CHK("pti", pulse_train_input, pti_o)
      end
      $display("end reset and reference test");
      tool = 1'b1;
      wait_own(2'h2);
      pjog = 1'b1;
      mode = 1'b1;
      tick(1);
      pjog = 1'b0;
      seed = lfsr(seed);
      {aref, pulse_train_input} = seed;
      spin = seed[7:0];
      tick(4);
      `CHK("owner", 2'h2, owner)
      `CHK("aref", 16'h0000, aref_o)
      `CHK("pti", 16'h0000, pti_o)
      `CHK("safety", spin, safe_o)
      {tool, mode} = 2'b00;
      wait_own(2'h0);
      for (i = 0; i < 2; i++) begin
         {pjog, ptune, mode} = {i == 0, i == 1, 1'b1};
         tick(1);
         {pjog, ptune} = 2'b00;
         wait_own(2'h1);
         tool = 1'b1;
         tick(4);
         `CHK("owner", 2'h1, owner)
         {tool, mode} = 2'b00;
         wait_own(2'h0);
      end
      acc(1'b1, 16'h3a02, 16'h0001, 16'h0000, 1'b0);
      `CHK("panel ok", 1'b0, pok)
      {pjog, mode} = 2'b11;
      tick(1);
      pjog = 1'b0;
      tick(4);
      `CHK("owner", 2'h0, owner)
      mode = 1'b0;
      acc(1'b1, 16'h3a02, 16'h0000, 16'h0000, 1'b0);
      `CHK("panel ok", 1'b1, pok)
      {oreq, mode} = 2'b11;
      acc(1'b1, 16'h011c, 16'h0001, 16'h0000, 1'b0);
      tick(2);
      `CHK("other ok", 1'b1, ook)
      mode = 1'b0;
      tick(2);
      `CHK("other ok", 1'b0, ook)
      tool = 1'b1;
      tick(4);
      `CHK("owner", 2'h0, owner)
      acc(1'b0, 16'h011c, 16'h0000, 16'h0001, 1'b0);
      acc(1'b1, 16'h011c, 16'h0000, 16'h0000, 1'b0);
      `CHK("other ok", 1'b1, ook)
      wait_own(2'h2);
      tool = 1'b0;
      wait_own(2'h0);
      $display("end arbiter and lock test");
      pwr = 1'b1;
      acc(1'b1, 16'h0404, 16'h0001, 16'h0000, 1'b1);
      acc(1'b0, 16'h0404, 16'h0000, 16'h0000, 1'b0);
      pwr = 1'b0;
      acc(1'b1, 16'h0404, 16'h0001, 16'h0000, 1'b0);
      acc(1'b0, 16'h0404, 16'h0000, 16'h0001, 1'b0);
      m_u.poll(16'h0404, 40, n);
      `CHK("save done", 1'b1, n < 40)
      for (i = 0; i < 4; i++) begin
         acc(1'b0, 16'(i), 16'h0000, 16'h0000, 1'b1);
         `CHK("stored", 16'(i), stp)
         `CHK("active", 16'h0000, actp)
      end
      pol = 1'b1;
      tick(1);
      pol = 1'b0;
      tick(2);
      for (i = 0; i < 4; i++) begin
         acc(1'b0, 16'(i), 16'h0000, 16'h0000, 1'b1);
         `CHK("active", 16'(i), actp)
      end
      acc(1'b1, 16'h3a02, 16'h0001, 16'h0000, 1'b0);
      pri = 1'b1;
      tick(1);
      pri = 1'b0;
      acc(1'b0, 16'h0404, 16'h0000, 16'h0000, 1'b0);
      acc(1'b1, 16'h3a02, 16'h0000, 16'h0000, 1'b0);
      pri = 1'b1;
      tick(1);
      pri = 1'b0;
      acc(1'b0, 16'h0404, 16'h0000, 16'h0001, 1'b0);
      m_u.poll(16'h0404, 40, n);
      `CHK("panel save done", 1'b1, n < 40)
      $display("end restore test");
      for (i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         pos = $signed(seed) >>> (i % 5);
         if (i < 4) pos = 32'hf0000000 + {{30{i[1]}}, i[1] ? i[1:0] : 2'h3};
         jog = i[0] | (i < 4);
         tick(2);
         `CHK("position", clampf(pos, jog), pos_o)
      end
      $display("end position test");
      conclude;
   end
endmodule
